/* rtl/rsc_pkg.sv */
package rsc_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_FUNC   = 8'h00;
    localparam logic [7:0] ADDR_CAUSE      = 8'h04;
    localparam logic [7:0] ADDR_BOR_LEVEL  = 8'h08;
    localparam logic [7:0] ADDR_FLASH_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_WDT_CTRL   = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h14;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PIN_FUNC_GPIO   = 8'h55;
    localparam logic [7:0] PIN_FUNC_CLEAR  = 8'haa;
    localparam logic [7:0] BOR_1V7         = 8'h66;
    localparam logic [7:0] BOR_1V9         = 8'h55;
    localparam logic [7:0] BOR_2V55        = 8'h33;
    localparam logic [7:0] BOR_3V15        = 8'h99;
    localparam logic [7:0] BOR_3V8         = 8'haa;
    localparam logic [7:0] BOR_OFF         = 8'hf0;
    localparam logic [7:0] FLASH_RESET_KEY = 8'h55;
    localparam logic [4:0] WDT_DISABLE     = 5'h15;
    localparam logic [4:0] WDT_ENABLE      = 5'h0a;
    localparam logic [7:0] WDT_CTRL_RESET  = 8'h53;

    // ------------------------------------------------------------------
    // Cause flag bit positions
    // ------------------------------------------------------------------
    localparam int FLAG_WDT_CTRL = 0;
    localparam int FLAG_BOR_SEL  = 1;
    localparam int FLAG_UNDERV   = 2;
    localparam int FLAG_PIN_SEL  = 3;

    // ------------------------------------------------------------------
    // Delays in system clock cycles (50 MHz)
    // ------------------------------------------------------------------
    localparam int SYS_CLK_MHZ       = 50;
    localparam int SOFT_RESET_NS     = 100;
    localparam int PIN_RELEASE_NS    = 200;
    localparam int BOR_FILTER_NS     = 200;
    localparam int SOFT_RESET_CYC    =
        (SOFT_RESET_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int PIN_RELEASE_CYC   =
        (PIN_RELEASE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int BOR_FILTER_CYC    =
        (BOR_FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CNT_W             = 16;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_RESET,
        ST_HOLD
    } rsc_state_t;
endpackage

/* rtl/rsc_reset_control.sv */
`timescale 1ns/1ps
// How it works
// - Power-on clears program counter to zero
// - Power-on loads port data, direction ones
// - Code 55h GPIO, AAh active-low clear pin
// - Other pin codes reset after soft delay
// - Pin select powers up at 55h
// - Bad pin code sets sticky flag
// - Qualified undervoltage sets sticky flag
// - Bad brownout code sets sticky flag
// - Supervision off in sleep and idle
// - Low voltage must outlast filter time
// - Five threshold codes, F0h disables
// - Brownout select powers up at 66h
// - Real undervoltage reset keeps brownout select
// - Bad brownout code resets, restores 66h
// - Flash control write 55h resets chip
// - Running watchdog timeout resets, sets expired
// - Sleeping timeout clears PC, SP only
// - Cause register: four flags, upper zero
// - Pin release adds start-up delay
// - Pin reset is normal operation reset
// - Bad watchdog code sets sticky flag
module rsc_reset_control
    import rsc_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Supply, watchdog and mode inputs
    input  wire logic        lowVoltage,
    input  wire logic        wdtTimeout,
    input  wire logic        haltMode,
    input  wire logic        wdtClear,
    // Shared pin input
    input  wire logic        sharedPinIn,
    // Reset outputs to core
    output logic             chipReset,
    output logic             normalReset,
    output logic             pcSpClear,
    output logic             pinIsClear,
    output logic             wdtEnable,
    output logic [2:0]       brownoutLevel,
    output logic             brownoutActive
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]        pinFuncSel;
    logic [7:0]        borLevelSel;
    logic [7:0]        wdtCtrl;
    logic [3:0]        causeFlags;
    logic              expiredFlag;
    logic              haltedFlag;
    logic [CNT_W-1:0]  softCnt;
    logic [CNT_W-1:0]  borCnt;
    logic [CNT_W-1:0]  holdCnt;
    rsc_state_t        state;
    logic              haltSeen;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire wrAcc  = psel && penable && pwrite;
    wire wrPin  = wrAcc && (paddr == ADDR_PIN_FUNC);
    wire wrCau  = wrAcc && (paddr == ADDR_CAUSE);
    wire wrBor  = wrAcc && (paddr == ADDR_BOR_LEVEL);
    wire wrFla  = wrAcc && (paddr == ADDR_FLASH_CTRL);
    wire wrWdt  = wrAcc && (paddr == ADDR_WDT_CTRL);
    wire wrSta  = wrAcc && (paddr == ADDR_STATUS);
    wire mapped = (paddr == ADDR_PIN_FUNC) || (paddr == ADDR_CAUSE)
               || (paddr == ADDR_BOR_LEVEL) || (paddr == ADDR_FLASH_CTRL)
               || (paddr == ADDR_WDT_CTRL) || (paddr == ADDR_STATUS);

    wire pinBad = (pinFuncSel != PIN_FUNC_GPIO)
               && (pinFuncSel != PIN_FUNC_CLEAR);
    wire borOff = (borLevelSel == BOR_OFF);
    wire borBad = !borOff && (borLevelSel != BOR_1V7)
               && (borLevelSel != BOR_1V9) && (borLevelSel != BOR_2V55)
               && (borLevelSel != BOR_3V15) && (borLevelSel != BOR_3V8);
    wire wdtBad = (wdtCtrl[7:3] != WDT_DISABLE)
               && (wdtCtrl[7:3] != WDT_ENABLE);
    wire softBad   = pinBad || borBad || wdtBad;
    wire softFire  = softBad && (softCnt == CNT_W'(SOFT_RESET_CYC - 1));
    wire borSupOn  = !borOff && !borBad && !haltMode;
    wire borFire   = borSupOn && lowVoltage
                  && (borCnt == CNT_W'(BOR_FILTER_CYC));
    wire flashFire = wrFla && (pwdata[7:0] == FLASH_RESET_KEY);
    wire pinClear  = (pinFuncSel == PIN_FUNC_CLEAR) && !sharedPinIn;
    wire wdtRun    = wdtTimeout && !haltMode;
    wire wdtSleep  = wdtTimeout && haltMode;
    wire fullFire  = softFire || borFire || flashFire || wdtRun;

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_HOLD;
            holdCnt <= '0;
        end else begin
            unique case (state)
                ST_RUN: begin
                    if (fullFire) begin
                        state <= ST_RESET;
                    end else if (pinClear) begin
                        state <= ST_RESET;
                    end
                    holdCnt <= '0;
                end
                ST_RESET: begin
                    if (!pinClear) begin
                        state <= ST_HOLD;
                    end
                    holdCnt <= '0;
                end
                ST_HOLD: begin
                    if (pinClear || fullFire) begin
                        state   <= ST_RESET;
                        holdCnt <= '0;
                    end else if (holdCnt == CNT_W'(PIN_RELEASE_CYC - 1)) begin
                        state   <= ST_RUN;
                    end else begin
                        holdCnt <= holdCnt + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Delay counters
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            softCnt <= '0;
            borCnt  <= '0;
        end else begin
            softCnt <= (softBad && !softFire) ? softCnt + CNT_W'(1) : '0;
            borCnt  <= (borSupOn && lowVoltage && !borFire)
                     ? borCnt + CNT_W'(1) : '0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinFuncSel  <= PIN_FUNC_GPIO;
            borLevelSel <= BOR_1V7;
            wdtCtrl     <= WDT_CTRL_RESET;
        end else begin
            if (softFire && pinBad) begin
                pinFuncSel <= PIN_FUNC_GPIO;
            end else if (wrPin) begin
                pinFuncSel <= pwdata[7:0];
            end
            // Qualified undervoltage leaves the level alone
            if (softFire && borBad) begin
                borLevelSel <= BOR_1V7;
            end else if (wrBor) begin
                borLevelSel <= pwdata[7:0];
            end
            if (softFire && wdtBad) begin
                wdtCtrl <= WDT_CTRL_RESET;
            end else if (wrWdt) begin
                wdtCtrl <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky flags: hardware set wins over software clear
    // ------------------------------------------------------------------
    wire [3:0] flagSet;
    assign flagSet[FLAG_PIN_SEL]  = softFire && pinBad;
    assign flagSet[FLAG_UNDERV]   = borFire;
    assign flagSet[FLAG_BOR_SEL]  = softFire && borBad;
    assign flagSet[FLAG_WDT_CTRL] = softFire && wdtBad;
    // Software clears with zero; ones written are ignored
    wire [3:0] flagClr = wrCau ? ~pwdata[3:0] : 4'h0;

    for (genvar i = 0; i < 4; i++) begin : g_flag
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                causeFlags[i] <= 1'b0;
            end else begin
                causeFlags[i] <= flagSet[i] || (causeFlags[i] && !flagClr[i]);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            expiredFlag <= 1'b0;
            haltedFlag  <= 1'b0;
            haltSeen    <= 1'b0;
        end else begin
            haltSeen <= haltMode;
            if (wdtTimeout) begin
                expiredFlag <= 1'b1;
            end else if (wdtClear || (wrSta && !pwdata[0])) begin
                expiredFlag <= 1'b0;
            end
            if (wdtSleep) begin
                haltedFlag <= 1'b1;
            end else if (haltMode && !haltSeen) begin
                haltedFlag <= 1'b1;
            end else if (wdtClear || (wrSta && !pwdata[1])) begin
                haltedFlag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Core clears PC to zero and loads port registers with ones on this
    assign chipReset      = (state != ST_RUN);
    assign normalReset    = (state != ST_RUN);
    assign pcSpClear      = (state != ST_RUN) || wdtSleep;
    assign pinIsClear     = (pinFuncSel == PIN_FUNC_CLEAR);
    assign wdtEnable      = (wdtCtrl[7:3] == WDT_ENABLE);
    assign brownoutActive = borSupOn;
    assign brownoutLevel  = (borLevelSel == BOR_1V9)  ? 3'h1 :
                            (borLevelSel == BOR_2V55) ? 3'h2 :
                            (borLevelSel == BOR_3V15) ? 3'h3 :
                            (borLevelSel == BOR_3V8)  ? 3'h4 : 3'h0;

    wire [31:0] rdMux =
        (paddr == ADDR_PIN_FUNC)  ? {24'h0, pinFuncSel}  :
        (paddr == ADDR_CAUSE)     ? {28'h0, causeFlags}  :
        (paddr == ADDR_BOR_LEVEL) ? {24'h0, borLevelSel} :
        (paddr == ADDR_WDT_CTRL)  ? {24'h0, wdtCtrl}     :
        (paddr == ADDR_STATUS)    ? {30'h0, haltedFlag, expiredFlag} :
        32'h0;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdMux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule

/* tb/rsc_reset_control_asserts.sv */
`timescale 1ns/1ps
module rsc_reset_control_asserts
    import rsc_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // Bus side
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Events and pin
    input wire logic       wdtTimeout,
    input wire logic       haltMode,
    input wire logic       sharedPinIn,
    // Reset outputs
    input wire logic       chipReset,
    input wire logic       normalReset,
    input wire logic       pcSpClear,
    input wire logic       pinIsClear,
    input wire logic       wdtEnable,
    input wire logic [2:0] brownoutLevel,
    input wire logic       brownoutActive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Mapped words are aligned and end at the status register
    wire logic unmapped = (paddr > ADDR_STATUS) || (paddr[1:0] != 2'b00);
    sequence pinHeld;
        pinIsClear && !sharedPinIn;
    endsequence
    sequence pinFreed;
        pinIsClear && $rose(sharedPinIn) && chipReset;
    endsequence
    ready_always_a: assert property (pready)
        else $error("pready low");
    slverr_map_a: assert property (psel && penable |-> pslverr == unmapped)
        else $error("pslverr does not match decode");
    reset_alias_a: assert property (normalReset == chipReset)
        else $error("normalReset differs from chipReset");
    pcsp_cause_a: assert property (chipReset
        || (wdtTimeout && haltMode) |-> pcSpClear)
        else $error("pcSpClear missing");
    halt_supervise_a: assert property (haltMode |-> !brownoutActive)
        else $error("supervision active in halt");
    level_range_a: assert property (brownoutLevel <= 3'd4)
        else $error("brownout level out of range");
    pin_clear_a: assert property (pinHeld |-> ##[0:2] chipReset)
        else $error("low clear pin gave no reset");
    pin_hold_a: assert property (pinFreed |-> chipReset[*8])
        else $error("start-up hold too short");
    wdt_run_a: assert property (wdtTimeout && !haltMode && wdtEnable
        |-> ##[0:2] chipReset) else $error("timeout gave no reset");
    halt_timeout_a: assert property (wdtTimeout && haltMode &&
        !chipReset |=> !chipReset) else $error("halt timeout reset chip");
endmodule

bind rsc_reset_control rsc_reset_control_asserts u_chk (.sys_clk, .arst_n,
    .psel, .penable, .paddr, .pready, .pslverr, .wdtTimeout, .haltMode,
    .sharedPinIn, .chipReset, .normalReset, .pcSpClear, .pinIsClear,
    .wdtEnable, .brownoutLevel, .brownoutActive);

/* tb/tb_mcu_reset_source_control.sv */
`timescale 1ns/1ps
module tb_mcu_reset_source_control;
    import rsc_pkg::*;
    logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic        lowVoltage, wdtTimeout, haltMode, wdtClear, sharedPinIn;
    logic        chipReset, normalReset, pcSpClear, pinIsClear, wdtEnable;
    logic        brownoutActive, err;
    logic [7:0]  paddr;
    logic [2:0]  brownoutLevel;
    logic [31:0] pwdata, prdata, rd;
    int          failures, tests_run, n;
    logic [7:0]  rowAddr [6] = '{ADDR_PIN_FUNC, ADDR_CAUSE, ADDR_BOR_LEVEL,
                                 ADDR_WDT_CTRL, ADDR_STATUS, 8'h18};
    logic [7:0]  rowData [6] = '{PIN_FUNC_GPIO, 8'h00, BOR_1V7,
                                 WDT_CTRL_RESET, 8'h00, 8'h00};
    logic        rowErr  [6] = '{0, 0, 0, 0, 0, 1};
    logic [7:0]  borCode [6] = '{BOR_1V7, BOR_1V9, BOR_2V55, BOR_3V15,
                                 BOR_3V8, BOR_OFF};

    rsc_reset_control DUT (.sys_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .lowVoltage, .wdtTimeout,
        .haltMode, .wdtClear, .sharedPinIn, .chipReset, .normalReset,
        .pcSpClear, .pinIsClear, .wdtEnable, .brownoutLevel, .brownoutActive);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            failures++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Each reset start or end waited on must come within 60 cycles or the run stops
    task automatic waitFor(input logic v);
        int k;
        for (k = 0; k < 60; k++) begin
            @(negedge sys_clk);
            if (chipReset === v) break;
        end
        if (k == 60) begin
            failures++;
            summarize();
        end
        @(posedge sys_clk);
    endtask
    // Sampled mid-cycle so registered outputs have settled
    task automatic holdLen(output int len);
        for (len = 0; len < 40; len++) begin
            @(negedge sys_clk);
            if (chipReset !== 1'b1) break;
        end
        @(posedge sys_clk);
    endtask
    task automatic fault(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        waitFor(1'b1);
        waitFor(1'b0);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {lowVoltage, wdtTimeout, haltMode, wdtClear} = '0;
        sharedPinIn = 1'b1;
        failures = 0;
        tests_run = 0;
        repeat (5) @(posedge sys_clk);
        chk(chipReset, 1'b1);
        arst_n <= 1'b1;
        holdLen(n);
        chk(n >= PIN_RELEASE_CYC - 1 && n <= PIN_RELEASE_CYC + 1, 1);
        chk(wdtEnable, 1'b1);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, rowAddr[i], 32'h0);
            chk(rd, {24'h0, rowData[i]});
            chk(err, rowErr[i]);
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ADDR_BOR_LEVEL, {24'h0, borCode[i]});
            @(posedge sys_clk);
            if (i < 5) chk(brownoutLevel, i);
            chk(brownoutActive, i < 5);
        end
        apb(1'b1, ADDR_BOR_LEVEL, {24'h0, BOR_2V55});
        haltMode <= 1'b1;
        @(posedge sys_clk);
        chk(brownoutActive, 1'b0);
        haltMode <= 1'b0;
        lowVoltage <= 1'b1;
        repeat (BOR_FILTER_CYC - 3) @(posedge sys_clk);
        lowVoltage <= 1'b0;
        repeat (15) @(posedge sys_clk);
        rdChk(ADDR_CAUSE, 32'h0);
        lowVoltage <= 1'b1;
        waitFor(1'b1);
        lowVoltage <= 1'b0;
        waitFor(1'b0);
        rdChk(ADDR_CAUSE, 32'h4);
        rdChk(ADDR_BOR_LEVEL, {24'h0, BOR_2V55});
        apb(1'b1, ADDR_CAUSE, 32'h0);
        rdChk(ADDR_CAUSE, 32'h0);
        fault(ADDR_PIN_FUNC, 8'h12);
        rdChk(ADDR_CAUSE, 32'h8);
        apb(1'b1, ADDR_CAUSE, 32'hff);
        rdChk(ADDR_CAUSE, 32'h8);
        apb(1'b1, ADDR_CAUSE, 32'h0);
        rdChk(ADDR_CAUSE, 32'h0);
        fault(ADDR_BOR_LEVEL, 8'h12);
        rdChk(ADDR_CAUSE, 32'h2);
        rdChk(ADDR_BOR_LEVEL, {24'h0, BOR_1V7});
        fault(ADDR_WDT_CTRL, 8'h00);
        rdChk(ADDR_CAUSE, 32'h3);
        apb(1'b1, ADDR_WDT_CTRL, {24'h0, WDT_DISABLE, 3'b011});
        @(posedge sys_clk);
        chk(wdtEnable, 1'b0);
        apb(1'b1, ADDR_WDT_CTRL, {24'h0, WDT_CTRL_RESET});
        fault(ADDR_FLASH_CTRL, FLASH_RESET_KEY);
        chk(tests_run > 0 && chipReset === 1'b0, 1);
        apb(1'b1, ADDR_PIN_FUNC, {24'h0, PIN_FUNC_CLEAR});
        @(posedge sys_clk);
        chk(pinIsClear, 1'b1);
        sharedPinIn <= 1'b0;
        waitFor(1'b1);
        repeat (20) @(posedge sys_clk);
        chk(chipReset, 1'b1);
        sharedPinIn <= 1'b1;
        holdLen(n);
        chk(n >= PIN_RELEASE_CYC - 1 && n <= PIN_RELEASE_CYC + 1, 1);
        rdChk(ADDR_PIN_FUNC, {24'h0, PIN_FUNC_CLEAR});
        apb(1'b1, ADDR_PIN_FUNC, {24'h0, PIN_FUNC_GPIO});
        apb(1'b1, ADDR_STATUS, 32'h0);
        wdtTimeout <= 1'b1;
        @(posedge sys_clk);
        wdtTimeout <= 1'b0;
        waitFor(1'b1);
        waitFor(1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'b01);
        apb(1'b1, ADDR_STATUS, 32'h0);
        haltMode <= 1'b1;
        @(posedge sys_clk);
        wdtTimeout <= 1'b1;
        @(posedge sys_clk);
        chk(pcSpClear, 1'b1);
        wdtTimeout <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(chipReset, 1'b0);
        haltMode <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'b11);
        wdtClear <= 1'b1;
        @(posedge sys_clk);
        wdtClear <= 1'b0;
        rdChk(ADDR_STATUS, 32'h0);
        // Second power-on in mid-run: flags and select codes start over
        apb(1'b1, ADDR_BOR_LEVEL, {24'h0, BOR_3V8});
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(chipReset, 1'b1);
        arst_n <= 1'b1;
        holdLen(n);
        chk(n >= PIN_RELEASE_CYC - 1 && n <= PIN_RELEASE_CYC + 1, 1);
        rdChk(ADDR_CAUSE, 32'h0);
        rdChk(ADDR_BOR_LEVEL, {24'h0, BOR_1V7});
        summarize();
    end
endmodule
